// >>> src/asc_cfg.svh
// Constants for the serial converter control and readout block
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH

// ==========================================================
// Register offsets (byte addresses, one word each)
`define ASC_CTRL_OFS      8'h00
`define ASC_STATUS_OFS    8'h04
`define ASC_RESULT_OFS    8'h08
`define ASC_TEST_OFS      8'h0c

// ==========================================================
// Control fields
`define ASC_CTRL_RST      2'h0
`define ASC_CTRL_NOCFG    0
`define ASC_CTRL_TEST     1

// ==========================================================
// Status fields
`define ASC_ST_SEL        0
`define ASC_ST_SAMPLE     1
`define ASC_ST_CONV       2
`define ASC_ST_WORD       3
`define ASC_ST_SINGLE     4
`define ASC_ST_ODD        5
`define ASC_ST_STATE_LO   6

// ==========================================================
// Serial framing and timing counts
`define ASC_CFG_BITS      2'h3
`define ASC_NOCFG_PULSE   2'h1
`define ASC_RES_BITS      10
`define ASC_RES_LAST      4'ha
`define ASC_CONV_HALF     5'h15
`define ASC_TEST_RST      10'h000

`endif

// >>> src/asc_pkg.sv
// Types shared by the serial converter control and readout block
package asc_pkg;

    // ==========================================================
    // Serial sequence states, Gray coded along the path through ASC_CFG
    typedef enum logic [2:0] {
        ASC_IDLE = 3'b000,
        ASC_HUNT = 3'b001,
        ASC_CFG  = 3'b011,
        ASC_LEAD = 3'b010,
        ASC_DATA = 3'b110,
        ASC_DONE = 3'b111
    } asc_state_t;

    // ==========================================================
    // Captured configuration field after the start bit
    typedef struct packed {
        logic single_ended_select;
        logic odd_sel;
        logic dummy;
    } asc_cfg_t;

    // ==========================================================
    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } asc_apb_req_t;

    // ==========================================================
    // Multiplexer switch settings to the analog front end
    typedef struct packed {
        logic input_channel_a_pos;
        logic input_channel_b_pos;
        logic input_channel_a_neg;
        logic input_channel_b_neg;
        logic gnd_neg;
    } asc_mux_t;

endpackage

// >>> src/asc_top.sv
// Serial configuration and readout logic of a 10-bit sampling converter
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "asc_cfg.svh"

module asc_top (
    input  wire logic                 mclk,          // System clock, 20 MHz
    input  wire logic                 resetn,        // Async reset, active low
    input  wire asc_pkg::asc_apb_req_t apb_req,      // APB request group
    output logic [31:0]               prdata,        // APB read data
    output logic                      pready,        // APB ready
    output logic                      pslverr,       // APB error on unmapped
    input  wire logic                 select_n,      // Select pin, active low
    input  wire logic                 shift_clk,     // Host shift clock pin
    input  wire logic                 cfg_in,        // Configuration data pin
    output logic                      data_out,      // Serial result data
    output logic                      data_out_oe,   // Result pin drive enable
    input  wire logic [9:0]           analog_code,   // Code from analog core
    output asc_pkg::asc_mux_t         mux_sel,       // Front end switch setting
    output logic                      sample_track,  // Sample switch closed
    output logic                      power_on,      // Interface powered
    output logic                      conv_power     // Converter core powered
);

    // ==========================================================
    // Declarations
    logic       cs_meta, cs_sync, cs_last;       // Select synchroniser
    logic       ck_meta, ck_sync, ck_last;       // Shift clock synchroniser
    logic       di_meta, di_sync;                // Data in synchroniser
    logic       ck_rise, ck_fall, cs_fall;       // Edge events
    asc_pkg::asc_state_t state;                  // Serial sequence state
    logic [1:0] bit_cnt;                         // Config bits or pulses seen
    logic [3:0] out_cnt;                         // Result bits launched
    logic [9:0] out_shift;                       // Result shift register
    logic [9:0] result;                          // Last held result
    asc_pkg::asc_cfg_t cfg;                      // Captured config field
    logic       word_done;                       // Config word complete
    logic       do_hold;                         // Hold edge event
    logic [4:0] conv_cnt;                        // Conversion half cycles left
    logic [1:0] ctrl;                            // Control register
    logic [9:0] test_code;                       // Test code register
    logic       acc_wr, setup_rd, hit;           // Bus decode terms

    // ==========================================================
    // Address decode, shared by write and error paths
    function automatic logic asc_hit(input logic [7:0] a);
        asc_hit = (a == `ASC_CTRL_OFS) || (a == `ASC_STATUS_OFS) ||
                  (a == `ASC_RESULT_OFS) || (a == `ASC_TEST_OFS);
    endfunction

    // ==========================================================
    // Pin synchronisers, two flops before any logic
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            ck_meta <= 1'b0;
            ck_sync <= 1'b0;
            di_meta <= 1'b0;
            di_sync <= 1'b0;
        end else begin
            cs_meta <= select_n;
            cs_sync <= cs_meta;
            ck_meta <= shift_clk;
            ck_sync <= ck_meta;
            di_meta <= cfg_in;
            di_sync <= di_meta;
        end
    end

    // ==========================================================
    // Edge history of the synchronised levels
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cs_last <= 1'b1;
            ck_last <= 1'b0;
        end else begin
            cs_last <= cs_sync;
            ck_last <= ck_sync;
        end
    end

    // ==========================================================
    // Edge events
    assign ck_rise = ck_sync & ~ck_last;
    assign ck_fall = ~ck_sync & ck_last;
    assign cs_fall = ~cs_sync & cs_last;

    // Hold edge: falling edge after dummy bit, or second pulse in variant
    assign do_hold = ck_fall && !cs_sync &&
                     (((state == asc_pkg::ASC_CFG) && word_done) ||
                      ((state == asc_pkg::ASC_HUNT) && ctrl[`ASC_CTRL_NOCFG] &&
                       (bit_cnt == `ASC_NOCFG_PULSE)));

    // ==========================================================
    // Serial sequence state
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= asc_pkg::ASC_IDLE;
        end else if (cs_sync) begin
            state <= asc_pkg::ASC_IDLE;
        end else begin
            case (state)
                asc_pkg::ASC_IDLE: begin
                    // Wait for select to fall
                    if (cs_fall) begin
                        state <= asc_pkg::ASC_HUNT;
                    end
                end
                asc_pkg::ASC_HUNT: begin
                    // Skip zeros, or count pulses in the variant
                    if (do_hold) begin
                        state <= asc_pkg::ASC_LEAD;
                    end else if (ck_rise && di_sync && !ctrl[`ASC_CTRL_NOCFG]) begin
                        state <= asc_pkg::ASC_CFG;
                    end
                end
                asc_pkg::ASC_CFG: begin
                    // Bits are captured in their own process
                    if (do_hold) begin
                        state <= asc_pkg::ASC_LEAD;
                    end
                end
                asc_pkg::ASC_LEAD: begin
                    // Second null bit goes out on this rise
                    if (ck_rise) begin
                        state <= asc_pkg::ASC_DATA;
                    end
                end
                asc_pkg::ASC_DATA: begin
                    // Leave once the last result bit is out
                    if (ck_rise && (out_cnt == `ASC_RES_LAST)) begin
                        state <= asc_pkg::ASC_DONE;
                    end
                end
                asc_pkg::ASC_DONE: begin
                    // Input ignored until select rises
                    state <= asc_pkg::ASC_DONE;
                end
                default: begin
                    state <= asc_pkg::ASC_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Config word capture and pulse count
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bit_cnt   <= 2'h0;
            word_done <= 1'b0;
            cfg       <= '0;
        end else if (cs_sync || (state == asc_pkg::ASC_IDLE)) begin
            // Deselect or idle: forget the partial word
            bit_cnt   <= 2'h0;
            word_done <= 1'b0;
        end else if (state == asc_pkg::ASC_HUNT) begin
            // Variant counts falling edges; otherwise zeros are skipped
            if (ctrl[`ASC_CTRL_NOCFG] && ck_fall) begin
                bit_cnt <= bit_cnt + 2'h1;
            end
        end else if ((state == asc_pkg::ASC_CFG) && ck_rise && !word_done) begin
            // Mode, polarity and dummy shift in turn
            cfg     <= {cfg.odd_sel, cfg.dummy, di_sync};
            bit_cnt <= bit_cnt + 2'h1;
            if (bit_cnt == (`ASC_CFG_BITS - 2'h1)) begin
                // Third bit in: word complete
                word_done <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Sample switch: from polarity bit to hold edge
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sample_track <= 1'b0;
        end else if (cs_sync || do_hold) begin
            sample_track <= 1'b0;
        end else if ((state == asc_pkg::ASC_CFG) && ck_rise && (bit_cnt == 2'h1)) begin
            sample_track <= 1'b1;
        end else if ((state == asc_pkg::ASC_HUNT) && ctrl[`ASC_CTRL_NOCFG] && ck_rise) begin
            // Variant has no polarity bit: track from the first rise
            sample_track <= 1'b1;
        end
    end

    // ==========================================================
    // Multiplexer decode, dummy bit left out
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mux_sel <= '0;
        end else begin
            // Switch order: a_pos, b_pos, a_neg, b_neg, gnd_neg
            case ({cfg.single_ended_select, cfg.odd_sel})
                2'b10: begin
                    // Channel A against ground
                    mux_sel <= asc_pkg::asc_mux_t'(5'b10001);
                end
                2'b11: begin
                    // Channel B against ground
                    mux_sel <= asc_pkg::asc_mux_t'(5'b01001);
                end
                2'b00: begin
                    // Channel A minus channel B
                    mux_sel <= asc_pkg::asc_mux_t'(5'b10010);
                end
                2'b01: begin
                    // Channel B minus channel A
                    mux_sel <= asc_pkg::asc_mux_t'(5'b01100);
                end
                default: begin
                    mux_sel <= '0;
                end
            endcase
        end
    end

    // ==========================================================
    // Conversion timing, counted in shift clock half cycles
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            conv_cnt <= 5'h00;
            result   <= 10'h000;
        end else if (do_hold) begin
            // Hold edge: start counting, freeze the code
            conv_cnt <= `ASC_CONV_HALF;
            result   <= ctrl[`ASC_CTRL_TEST] ? test_code : analog_code;
        end else if ((conv_cnt != 5'h00) && (ck_rise || ck_fall)) begin
            // One step per shift clock edge
            conv_cnt <= conv_cnt - 5'h01;
        end
    end

    // ==========================================================
    // Serial output: null bits then result, high impedance otherwise
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            data_out    <= 1'b0;
            data_out_oe <= 1'b0;
            out_cnt     <= 4'h0;
            out_shift   <= 10'h000;
        end else if (cs_sync) begin
            // Deselect: line back to high impedance
            data_out    <= 1'b0;
            data_out_oe <= 1'b0;
            out_cnt     <= 4'h0;
        end else if (do_hold) begin
            // First null bit, line taken on the falling edge
            data_out    <= 1'b0;
            data_out_oe <= 1'b1;
            out_cnt     <= 4'h0;
            out_shift   <= ctrl[`ASC_CTRL_TEST] ? test_code : analog_code;
        end else if (ck_rise && (state == asc_pkg::ASC_LEAD)) begin
            // Second null bit
            data_out <= 1'b0;
        end else if (ck_rise && (state == asc_pkg::ASC_DATA)) begin
            if (out_cnt == `ASC_RES_LAST) begin
                // Past the last bit: release the line
                data_out    <= 1'b0;
                data_out_oe <= 1'b0;
            end else begin
                // Next result bit, most significant first
                data_out  <= out_shift[`ASC_RES_BITS-1];
                out_shift <= {out_shift[`ASC_RES_BITS-2:0], 1'b0};
                out_cnt   <= out_cnt + 4'h1;
            end
        end
    end

    // ==========================================================
    // Power indicators
    assign power_on   = ~cs_sync;
    assign conv_power = ~cs_sync && ((conv_cnt != 5'h00) || sample_track);

    // ==========================================================
    // APB slave, zero wait states
    assign hit      = asc_hit(apb_req.paddr);
    assign acc_wr   = apb_req.psel && apb_req.penable && apb_req.pwrite && hit;
    assign setup_rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
    // Every access completes in its first access cycle
    assign pready   = 1'b1;
    assign pslverr  = apb_req.psel && apb_req.penable && !hit;

    // ==========================================================
    // Writable registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl      <= `ASC_CTRL_RST;
            test_code <= `ASC_TEST_RST;
        end else if (acc_wr) begin
            if (apb_req.paddr == `ASC_CTRL_OFS) begin
                // Variant and test code selects
                ctrl <= apb_req.pwdata[1:0];
            end
            if (apb_req.paddr == `ASC_TEST_OFS) begin
                // Code sent in place of the analog one
                test_code <= apb_req.pwdata[9:0];
            end
        end
    end

    // ==========================================================
    // Read data latched in the setup cycle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_rd) begin
            case (apb_req.paddr)
                `ASC_CTRL_OFS: begin
                    prdata <= {30'h0, ctrl};
                end
                `ASC_STATUS_OFS: begin
                    prdata <= {23'h0, state, cfg.odd_sel, cfg.single_ended_select,
                               word_done, (conv_cnt != 5'h00), sample_track, ~cs_sync};
                end
                `ASC_RESULT_OFS: begin
                    prdata <= {22'h0, result};
                end
                `ASC_TEST_OFS: begin
                    prdata <= {22'h0, test_code};
                end
                default: begin
                    prdata <= 32'h0000_0000;
                end
            endcase
        end
    end

endmodule

// >>> verif/asc_checker_assertions.sv
// Concurrent checks on the converter control block ports
`timescale 1ns/1ps
module asc_checker (
    input wire logic                  mclk,         // System clock
    input wire logic                  resetn,       // Async reset, active low
    input wire asc_pkg::asc_apb_req_t apb_req,      // APB request
    input wire logic [31:0]           prdata,       // APB read data
    input wire logic                  pready,       // APB ready
    input wire logic                  pslverr,      // APB error
    input wire logic                  select_n,     // Select pin
    input wire logic                  shift_clk,    // Shift clock pin
    input wire logic                  cfg_in,       // Config pin
    input wire logic                  data_out,     // Serial data
    input wire logic                  data_out_oe,  // Drive enable
    input wire logic [9:0]            analog_code,  // Analog core code
    input wire asc_pkg::asc_mux_t     mux_sel,      // Mux setting
    input wire logic                  sample_track, // Sample switch
    input wire logic                  power_on,     // Interface powered
    input wire logic                  conv_power    // Core powered
);
    // ==========================================================
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    pready_high_a: assert property (pready) else $error("pready low");
    unmapped_err_a: assert property (pslverr |-> apb_req.psel && apb_req.penable
        && (apb_req.pwrite || prdata == 32'h0)) else $error("bad error response");
    power_off_a: assert property (select_n [*6] |-> !power_on && !conv_power)
        else $error("powered while deselected");
    power_on_a: assert property (!select_n [*6] |-> power_on)
        else $error("unpowered while selected");
    oe_idle_a: assert property (select_n [*8] |-> !data_out_oe && !sample_track)
        else $error("drive while deselected");
    abort_off_a: assert property ($rose(select_n) |-> ##[1:8] !data_out_oe)
        else $error("output not released");
    oe_on_fall_a: assert property ($rose(data_out_oe) |-> !shift_clk && !data_out && !select_n)
        else $error("bad output enable");
    data_on_rise_a: assert property (data_out_oe && $past(data_out_oe)
        && data_out != $past(data_out) |-> shift_clk)
        else $error("data changed off rise");
    track_rise_a: assert property ($rose(sample_track) |-> shift_clk && power_on)
        else $error("sampling start wrong");
    conv_gate_a: assert property (conv_power |-> power_on)
        else $error("core powered when off");
    // Main scenarios reached
    cover property ($rose(data_out_oe));
    cover property (pslverr);
    cover property ($fell(sample_track));
endmodule

bind asc_top asc_checker chk (.mclk(mclk), .resetn(resetn), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .select_n(select_n),
    .shift_clk(shift_clk), .cfg_in(cfg_in), .data_out(data_out), .data_out_oe(data_out_oe),
    .analog_code(analog_code), .mux_sel(mux_sel), .sample_track(sample_track),
    .power_on(power_on), .conv_power(conv_power));

// >>> verif/asc_host.sv
// Host side model: select, shift clock and config pin, collects result
`timescale 1ns/1ps
module asc_host #(
    parameter int H = 6                          // Mclk per shift clock level
) (
    input  wire logic              mclk,        // System clock
    input  wire logic              data_out,    // Device serial data
    input  wire logic              data_out_oe, // Device drive enable
    input  wire asc_pkg::asc_mux_t mux_sel,     // Device mux setting
    output logic                   select_n,    // Select, active low
    output logic                   shift_clk,   // Shift clock, idle low
    output logic                   cfg_in       // Config data
);
    logic drv = 1'b0;                            // Driven config bit
    logic rel = 1'b1;                            // Wire released
    logic pat = 1'b0;                            // Changing pattern
    initial begin
        select_n = 1'b1;
        shift_clk = 1'b0;
    end
    // Released wire shows a pattern, never the last bit
    always @(posedge mclk) pat <= ~pat;
    assign cfg_in = rel ? pat : drv;
    // One exchange of n shift clock pulses
    task automatic xfer(input int zeros, input bit nocfg, input logic [2:0] word, input int n,
                        output logic [11:0] bits, output logic ok, output asc_pkg::asc_mux_t mx);
        int base;
        base = nocfg ? 2 : zeros + 4;
        bits = '0;
        ok = 1'b1;
        mx = '0;
        @(posedge mclk);
        select_n <= 1'b0;
        rel <= nocfg;
        repeat (H) @(posedge mclk);
        for (int k = 0; k < n; k++) begin
            // Launch in low phase, device samples at rise
            if (k <= zeros) drv <= (k == zeros);
            else if (k <= zeros + 3) drv <= word[zeros + 3 - k];
            repeat (H) @(posedge mclk);
            if (k >= base && k < base + 12) begin
                bits[base + 11 - k] = data_out;
                ok &= data_out_oe;
            end
            if (k == base) mx = mux_sel;
            shift_clk <= 1'b1;
            repeat (H / 2) @(posedge mclk);
            if (k == zeros + 3) rel <= 1'b1;
            repeat (H - H / 2) @(posedge mclk);
            shift_clk <= 1'b0;
        end
        repeat (H) @(posedge mclk);
        if (n >= base + 12) ok &= !data_out_oe;
        select_n <= 1'b1;
        rel <= 1'b1;
        repeat (3 * H) @(posedge mclk);
    endtask
endmodule

// >>> verif/test_adc_serial_config_readout.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "asc_cfg.svh"
module test_adc_serial_config_readout;
    logic                  mclk = 1'b0;     // System clock
    logic                  resetn = 1'b0;   // Reset, active low
    asc_pkg::asc_apb_req_t apb_req = '0;    // APB request
    logic [31:0]           prdata;          // APB read data
    logic                  pready;          // APB ready
    logic                  pslverr;         // APB error
    logic                  select_n;        // Select pin
    logic                  shift_clk;       // Shift clock
    logic                  cfg_in;          // Config pin
    logic                  data_out;        // Serial data
    logic                  data_out_oe;     // Drive enable
    logic [9:0]            analog_code = '0; // Analog core code
    asc_pkg::asc_mux_t     mux_sel;         // Mux setting
    logic                  sample_track;    // Sample switch
    logic                  power_on;        // Powered
    logic                  conv_power;      // Core powered
    int                    n_errors = 0;    // Mismatches
    int                    compares = 0;    // Comparisons
    int                    exp_q[$];        // Expected codes
    logic [4:0]            mtab[4] = '{5'h12, 5'h0c, 5'h11, 5'h09}; // Mux by mode, polarity

    initial forever #25 mclk = ~mclk;

    asc_top dut (.mclk(mclk), .resetn(resetn), .apb_req(apb_req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .select_n(select_n), .shift_clk(shift_clk),
        .cfg_in(cfg_in), .data_out(data_out), .data_out_oe(data_out_oe),
        .analog_code(analog_code), .mux_sel(mux_sel), .sample_track(sample_track),
        .power_on(power_on), .conv_power(conv_power));
    asc_host host (.mclk(mclk), .data_out(data_out), .data_out_oe(data_out_oe),
        .mux_sel(mux_sel), .select_n(select_n), .shift_clk(shift_clk), .cfg_in(cfg_in));

    // ==========================================================
    // Shared tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int t;
        @(posedge mclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        t = 0;
        do begin
            @(posedge mclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        rd = prdata;
        err = pslverr;
        if (t >= 50) n_errors++;
        apb_req <= '0;
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (60000) @(posedge mclk);
        n_errors++;
        tally_and_finish();
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] rd;
        logic err;
        logic [11:0] bits;
        logic ok;
        asc_pkg::asc_mux_t mx;
        int code;
        int z;
        void'($urandom(87954));
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        apb(0, `ASC_CTRL_OFS, 0, rd, err);
        check("ctrl_reset", rd, 0);
        apb(0, `ASC_TEST_OFS, 0, rd, err);
        check("test_reset", rd, 0);
        apb(1, `ASC_TEST_OFS, 32'hffffffff, rd, err);
        apb(0, `ASC_TEST_OFS, 0, rd, err);
        check("test_rw", rd, 32'h3ff);
        apb(1, 8'h10, 32'h5, rd, err);
        check("unmapped_wr_err", err, 1);
        apb(0, 8'h10, 0, rd, err);
        check("unmapped_rd", {rd[30:0], err}, 1);
        apb(0, `ASC_STATUS_OFS, 0, rd, err);
        check("status_idle", {rd[8:6], rd[0]}, 0);
        $display("register test done");
        // Abort in mid-result, then recovery below
        host.xfer(1, 1'b0, 3'b100, 7, bits, ok, mx);
        check("oe_after_abort", data_out_oe, 0);
        check("power_after_abort", power_on, 0);
        $display("abort test done");
        // Every mode, polarity and dummy value, leading zeros random
        for (int i = 0; i < 8; i++) begin
            code = (i < 2) ? i : $urandom % 1024;
            z = $urandom % 4;
            analog_code <= i[0] ? code[9:0] : ~code[9:0];
            apb(1, `ASC_TEST_OFS, code, rd, err);
            apb(1, `ASC_CTRL_OFS, i[0] ? 32'h0 : 32'h2, rd, err);
            exp_q.push_back(code);
            host.xfer(z, 1'b0, i[2:0], z + 16, bits, ok, mx);
            check("frame_bits", bits, exp_q.pop_front());
            check("frame_drive", ok, 1);
            check("mux", {27'h0, mx}, mtab[i[2:1]]);
            apb(0, `ASC_RESULT_OFS, 0, rd, err);
            check("result_reg", rd, code);
            $display("frame test %0d done", i);
        end
        // Variant without configuration word
        apb(1, `ASC_TEST_OFS, 32'h155, rd, err);
        apb(1, `ASC_CTRL_OFS, 32'h3, rd, err);
        host.xfer(0, 1'b1, 3'b000, 14, bits, ok, mx);
        check("nocfg_bits", bits, 32'h155);
        check("nocfg_drive", ok, 1);
        $display("no-config test done");
        tally_and_finish();
    end
endmodule
